// ---- src/eprom_host_pkg.sv ----
// Constants for the EPROM programmer/reader controller.
// Assumes a 20 MHz system clock; times are converted to cycles here.
package eprom_host_pkg;
    // ========================================================
    // Geometry
    localparam int ADDR_W = 15;
    localparam int DATA_W = 8;
    localparam int MEM_BYTES = 32768;
    // ========================================================
    // Timing
    localparam int CLK_HZ = 20_000_000;
    localparam int CLK_NS = 50;
    localparam int PULSE_US = 100;
    localparam int PULSE_CYC = (PULSE_US * 1000) / CLK_NS;
    localparam int ACCESS_NS = 200;
    localparam int ACCESS_CYC = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
    localparam int SETUP_NS = 100;
    localparam int SETUP_CYC = (SETUP_NS + CLK_NS - 1) / CLK_NS;
    localparam int MAX_PULSES = 25;
    localparam int CNT_W = 12;
    localparam logic [CNT_W-1:0] PULSE_CNT = CNT_W'(PULSE_CYC);
    localparam logic [CNT_W-1:0] ACCESS_CNT = CNT_W'(ACCESS_CYC);
    localparam logic [CNT_W-1:0] SETUP_CNT = CNT_W'(SETUP_CYC);
    localparam logic [CNT_W-1:0] CNT_ONE = 12'h001;
    localparam logic [CNT_W-1:0] CNT_ZERO = 12'h000;
    localparam logic [4:0] TRIES_MAX = 5'(MAX_PULSES);
    // ========================================================
    // Commands
    localparam logic [1:0] CMD_READ = 2'h0;
    localparam logic [1:0] CMD_PROG = 2'h1;
    localparam logic [1:0] CMD_IDENT = 2'h2;
    localparam logic [ADDR_W-1:0] ADDR_ZERO = 15'h0000;
    localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
    localparam logic [DATA_W-1:0] BLANK_BYTE = 8'hFF;
endpackage

// ---- src/eprom_host.sv ----
// Host controller that reads, programs and identifies a 32K x 8 EPROM.
// Assumes external level shifters turn o_vpp_high / o_sig_high into the
// program supply and identification voltage on the memory pins.
//
// Function
// - Program with high supply, gate high and a low select pulse, all eight bits driven.
// - Each byte other than FF gets fixed-width pulses, each followed by a verify, until it reads correct or 25 pulses are spent.
// - No extra pulse follows a byte that verified correctly.
// - Parallel devices may share all inputs except select.
// - Each programmed location is read back in verify mode.
// - Identification is requested with the signature line at high voltage, both enables low.
// - During identification all other address lines are held low.
// - Select is decoded per device and output gate follows the read strobe; this host has one undecoded o_sel_n and drives o_gate_n from its own sequencer.
`timescale 1ns/1ps
module eprom_host (
    input wire logic i_clk_sys,
    input wire logic i_nrst,
    input wire logic i_start,
    input wire logic [1:0] i_cmd,
    input wire logic [14:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic [7:0] i_data_lines,
    output logic o_busy,
    output logic o_done,
    output logic o_fail,
    output logic [7:0] o_rdata,
    output logic [14:0] o_address_lines,
    output logic [7:0] o_data_lines,
    output logic o_data_lines_oe_n,
    output logic o_sel_n,
    output logic o_gate_n,
    output logic o_vpp_high,
    output logic o_sig_high
);
    typedef enum logic [3:0] {
        ST_IDLE, ST_RD_WAIT, ST_ID_SETUP, ST_PG_SETUP, ST_PG_PULSE,
        ST_PG_GAP, ST_VF_WAIT, ST_FINISH
    } state_e;

    state_e state_reg, state_next;
    logic [11:0] cnt_reg, cnt_next;
    logic [4:0] tries_reg, tries_next;
    logic [7:0] din_s1_reg, din_reg;
    logic busy_reg, busy_next, done_reg, done_next, fail_reg, fail_next;
    logic [7:0] rdata_reg, rdata_next, wdata_reg, wdata_next;
    logic [14:0] addr_reg, addr_next;
    logic [7:0] dout_reg, dout_next;
    logic doe_n_reg, doe_n_next, sel_n_reg, sel_n_next;
    logic gate_n_reg, gate_n_next, vpp_reg, vpp_next, sig_reg, sig_next;

    // ========================================================
    // Pin synchroniser: the data bus is asynchronous to i_clk_sys
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            din_s1_reg <= eprom_host_pkg::DATA_ZERO;
            din_reg <= eprom_host_pkg::DATA_ZERO;
        end else begin
            din_s1_reg <= i_data_lines;
            din_reg <= din_s1_reg;
        end
    end

    // ========================================================
    // Sequencer next state
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        tries_next = tries_reg;
        busy_next = busy_reg;
        done_next = 1'b0;
        fail_next = fail_reg;
        rdata_next = rdata_reg;
        wdata_next = wdata_reg;
        addr_next = addr_reg;
        dout_next = dout_reg;
        doe_n_next = doe_n_reg;
        sel_n_next = sel_n_reg;
        gate_n_next = gate_n_reg;
        vpp_next = vpp_reg;
        sig_next = sig_reg;
        if (cnt_reg != eprom_host_pkg::CNT_ZERO) begin
            cnt_next = cnt_reg - eprom_host_pkg::CNT_ONE;
        end
        case (state_reg)
            ST_IDLE: begin
                // Idle: memory in standby, bus floating, safe supplies
                sel_n_next = 1'b1;
                gate_n_next = 1'b1;
                doe_n_next = 1'b1;
                vpp_next = 1'b0;
                sig_next = 1'b0;
                busy_next = 1'b0;
                if (i_start) begin
                    busy_next = 1'b1;
                    fail_next = 1'b0;
                    tries_next = 5'h00;
                    wdata_next = i_wdata;
                    addr_next = i_addr;
                    case (i_cmd)
                        eprom_host_pkg::CMD_PROG: begin
                            // A byte of all ones needs no pulse at all
                            if (i_wdata == eprom_host_pkg::BLANK_BYTE) begin
                                state_next = ST_FINISH;
                            end else begin
                                vpp_next = 1'b1;
                                dout_next = i_wdata;
                                doe_n_next = 1'b0;
                                cnt_next = eprom_host_pkg::SETUP_CNT;
                                state_next = ST_PG_SETUP;
                            end
                        end
                        eprom_host_pkg::CMD_IDENT: begin
                            // Only signature and byte select lines may be set
                            addr_next = {14'h0000, i_addr[0]};
                            sig_next = 1'b1;
                            cnt_next = eprom_host_pkg::SETUP_CNT;
                            state_next = ST_ID_SETUP;
                        end
                        default: begin
                            sel_n_next = 1'b0;
                            gate_n_next = 1'b0;
                            cnt_next = eprom_host_pkg::ACCESS_CNT;
                            state_next = ST_RD_WAIT;
                        end
                    endcase
                end
            end
            ST_ID_SETUP: begin
                // Let the high voltage settle before enabling outputs
                if (cnt_reg == eprom_host_pkg::CNT_ZERO) begin
                    sel_n_next = 1'b0;
                    gate_n_next = 1'b0;
                    cnt_next = eprom_host_pkg::ACCESS_CNT;
                    state_next = ST_RD_WAIT;
                end
            end
            ST_RD_WAIT: begin
                // Access count includes the two sync stages; pins sampled 3 cycles after gate low
                if (cnt_reg == eprom_host_pkg::CNT_ZERO) begin
                    rdata_next = din_reg;
                    state_next = ST_FINISH;
                end
            end
            ST_PG_SETUP: begin
                if (cnt_reg == eprom_host_pkg::CNT_ZERO) begin
                    sel_n_next = 1'b0;
                    tries_next = tries_reg + 5'h01;
                    cnt_next = eprom_host_pkg::PULSE_CNT;
                    state_next = ST_PG_PULSE;
                end
            end
            ST_PG_PULSE: begin
                // Fixed width pulse; select goes high to end it
                if (cnt_reg == eprom_host_pkg::CNT_ZERO) begin
                    sel_n_next = 1'b1;
                    doe_n_next = 1'b1;
                    cnt_next = eprom_host_pkg::SETUP_CNT;
                    state_next = ST_PG_GAP;
                end
            end
            ST_PG_GAP: begin
                // Bus released before gate goes low: avoids contention
                if (cnt_reg == eprom_host_pkg::CNT_ZERO) begin
                    gate_n_next = 1'b0;
                    cnt_next = eprom_host_pkg::ACCESS_CNT;
                    state_next = ST_VF_WAIT;
                end
            end
            ST_VF_WAIT: begin
                if (cnt_reg == eprom_host_pkg::CNT_ZERO) begin
                    gate_n_next = 1'b1;
                    rdata_next = din_reg;
                    if (din_reg == wdata_reg) begin
                        state_next = ST_FINISH;
                    end else if (tries_reg >= eprom_host_pkg::TRIES_MAX) begin
                        fail_next = 1'b1;
                        state_next = ST_FINISH;
                    end else begin
                        doe_n_next = 1'b0;
                        cnt_next = eprom_host_pkg::SETUP_CNT;
                        state_next = ST_PG_SETUP;
                    end
                end
            end
            ST_FINISH: begin
                sel_n_next = 1'b1;
                gate_n_next = 1'b1;
                doe_n_next = 1'b1;
                vpp_next = 1'b0;
                sig_next = 1'b0;
                busy_next = 1'b0;
                done_next = 1'b1;
                state_next = ST_IDLE;
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // ========================================================
    // Sequencer registers
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            state_reg <= ST_IDLE;
            cnt_reg <= eprom_host_pkg::CNT_ZERO;
            tries_reg <= 5'h00;
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
            fail_reg <= 1'b0;
            rdata_reg <= eprom_host_pkg::DATA_ZERO;
            wdata_reg <= eprom_host_pkg::DATA_ZERO;
            addr_reg <= eprom_host_pkg::ADDR_ZERO;
            dout_reg <= eprom_host_pkg::DATA_ZERO;
            doe_n_reg <= 1'b1;
            sel_n_reg <= 1'b1;
            gate_n_reg <= 1'b1;
            vpp_reg <= 1'b0;
            sig_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            tries_reg <= tries_next;
            busy_reg <= busy_next;
            done_reg <= done_next;
            fail_reg <= fail_next;
            rdata_reg <= rdata_next;
            wdata_reg <= wdata_next;
            addr_reg <= addr_next;
            dout_reg <= dout_next;
            doe_n_reg <= doe_n_next;
            sel_n_reg <= sel_n_next;
            gate_n_reg <= gate_n_next;
            vpp_reg <= vpp_next;
            sig_reg <= sig_next;
        end
    end

    assign o_busy = busy_reg;
    assign o_done = done_reg;
    assign o_fail = fail_reg;
    assign o_rdata = rdata_reg;
    assign o_address_lines = addr_reg;
    assign o_data_lines = dout_reg;
    assign o_data_lines_oe_n = doe_n_reg;
    assign o_sel_n = sel_n_reg;
    assign o_gate_n = gate_n_reg;
    assign o_vpp_high = vpp_reg;
    assign o_sig_high = sig_reg;

    // ========================================================
    // Checks
    a_pulse_gate_high: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        (vpp_reg && !sel_n_reg) |-> (gate_n_reg && !doe_n_reg))
        else $error("program pulse without gate high and data driven");
    a_no_contention: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        !gate_n_reg |-> doe_n_reg)
        else $error("host drives bus while memory output gated on");
    a_pulse_width: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        $fell(sel_n_reg) && vpp_reg |-> !sel_n_reg [*8])
        else $error("program pulse too short");
    a_verify_select: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        (vpp_reg && !gate_n_reg) |-> sel_n_reg)
        else $error("verify with select low");
    a_ident_addr: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        sig_reg |-> (addr_reg[14:1] == 14'h0000))
        else $error("address lines not low in identification");
    a_ident_no_vpp: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        sig_reg |-> !vpp_reg && doe_n_reg)
        else $error("identification with program supply or bus driven");
    a_verify_stop: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        (state_reg == ST_VF_WAIT && cnt_reg == eprom_host_pkg::CNT_ZERO &&
        din_reg == wdata_reg)
        |=> state_reg == ST_FINISH ##1 done_reg)
        else $error("pulse after good verify");
    a_read_access: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        $fell(gate_n_reg) && !vpp_reg |-> !gate_n_reg [*4])
        else $error("read sampled before access delay");
    a_idle_standby: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        !busy_reg && !done_reg |-> sel_n_reg && doe_n_reg)
        else $error("memory selected while idle");
endmodule // eprom_host

// ---- testbench/eprom_model.sv ----
// Behavioural 32K x 8 EPROM seen from its pins, for the host bench.
// Assumes the bench resolves the shared data wire and feeds it back in.
`timescale 1ns/1ps
module eprom_model #(
    parameter logic [7:0] MAKER_CODE = 8'h5A, // Arbitrary value
    parameter logic [7:0] PART_CODE = 8'hC3, // Arbitrary value
    parameter int ACC_NS = 80
) (
    input wire logic [14:0] i_address_lines,
    input wire logic [7:0] i_data_lines,
    input wire logic i_sel_n,
    input wire logic i_gate_n,
    input wire logic i_vpp_high,
    input wire logic i_sig_high,
    input wire logic [7:0] i_pulses_needed,
    output logic [7:0] o_data_lines,
    output logic [15:0] o_pulse_total
);
    // ========================================================
    // Storage, blank cells read as ones
    logic [7:0] mem [0:32767];
    logic [7:0] pcnt [0:32767];
    logic [7:0] val;
    logic [7:0] last;
    logic [7:0] latch_d;
    logic [14:0] latch_a;
    logic drive;
    initial begin
        for (int i = 0; i < 32768; i++) begin
            mem[i] = 8'hFF;
            pcnt[i] = 8'h00;
        end
        last = 8'h00;
        o_pulse_total = 16'h0000;
    end
    // ========================================================
    // Output control: gate passes data, select or program supply powers the part
    always_comb begin
        drive = !i_gate_n && (!i_sel_n || i_vpp_high);
        if (i_sig_high && !i_sel_n) begin
            val = i_address_lines[0] ? PART_CODE : MAKER_CODE;
        end else begin
            val = mem[i_address_lines];
        end
    end
    // Released wire shows the inverse, so a stale byte never looks valid
    always @* if (drive) last = val;
    assign #(ACC_NS) o_data_lines = drive ? val : ~last;
    // ========================================================
    // Program pulse: data latched as select falls, committed as it rises
    always @(negedge i_sel_n) begin
        latch_d = i_data_lines;
        latch_a = i_address_lines;
    end
    // Weak cells need several pulses; only zeros can ever be written
    always @(posedge i_sel_n) begin
        if (i_vpp_high && i_gate_n) begin
            o_pulse_total = o_pulse_total + 16'h0001;
            pcnt[latch_a] = pcnt[latch_a] + 8'h01;
            if (pcnt[latch_a] >= i_pulses_needed) begin
                mem[latch_a] = mem[latch_a] & latch_d;
            end
        end
    end
endmodule // eprom_model

// ---- testbench/tb_eprom_access_control.sv ----
// Self-checking bench for the EPROM host controller.
// Assumes the design package, the design and eprom_model are compiled.
`timescale 1ns/1ps
module tb_eprom_access_control;
    localparam logic [7:0] MAKER = 8'h5A; // Arbitrary value
    localparam logic [7:0] PART = 8'hC3; // Arbitrary value
    logic i_clk_sys, i_nrst, i_start;
    logic [1:0] i_cmd;
    logic [14:0] i_addr, addr_lines, a;
    logic [7:0] i_wdata, bus, rdata, host_q, mem_q, needed, d;
    logic busy, done, fail, oe_n, sel_n, gate_n, vpp, sig;
    logic [15:0] ptot, ptot_idle;
    logic [7:0] shadow [int];
    int failures, samples_checked;
    integer seed;
    // ========================================================
    // Clock and shared data wire
    initial begin
        i_clk_sys = 1'b0;
        forever #25 i_clk_sys = ~i_clk_sys;
    end
    assign bus = !oe_n ? host_q : mem_q;
    eprom_host DUT (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst),
        .i_start(i_start), .i_cmd(i_cmd), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_data_lines(bus), .o_busy(busy),
        .o_done(done), .o_fail(fail), .o_rdata(rdata),
        .o_address_lines(addr_lines), .o_data_lines(host_q),
        .o_data_lines_oe_n(oe_n), .o_sel_n(sel_n), .o_gate_n(gate_n),
        .o_vpp_high(vpp), .o_sig_high(sig));
    eprom_model #(.MAKER_CODE(MAKER), .PART_CODE(PART)) mem_dev (
        .i_address_lines(addr_lines), .i_data_lines(bus),
        .i_sel_n(sel_n), .i_gate_n(gate_n), .i_vpp_high(vpp),
        .i_sig_high(sig), .i_pulses_needed(needed),
        .o_data_lines(mem_q), .o_pulse_total(ptot));
    // Second part on the same pins but its own select, held high throughout
    eprom_model #(.MAKER_CODE(MAKER), .PART_CODE(PART)) idle_dev (
        .i_address_lines(addr_lines), .i_data_lines(bus),
        .i_sel_n(1'b1), .i_gate_n(gate_n), .i_vpp_high(vpp),
        .i_sig_high(sig), .i_pulses_needed(needed),
        .o_data_lines(), .o_pulse_total(ptot_idle));
    // ========================================================
    // Expectations
    function automatic logic [7:0] stored(input logic [14:0] x);
        return shadow.exists(int'(x)) ? shadow[int'(x)] : 8'hFF;
    endfunction
    function automatic logic exp_fail(input logic [7:0] o, input logic [7:0] w);
        return (w != 8'hFF) && ((o & w) != w);
    endfunction
    // Blank request needs no pulse; an impossible one uses the whole budget
    function automatic logic [7:0] exp_pulses(input logic [7:0] o,
            input logic [7:0] w, input logic [7:0] n);
        if (w == 8'hFF) return 8'h00;
        if (exp_fail(o, w)) return 8'(eprom_host_pkg::TRIES_MAX);
        return n;
    endfunction
    // ========================================================
    // Tasks
    task automatic chk(input string what, input logic [7:0] exp,
            input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Called at a falling edge; returns at the falling edge showing done
    task automatic run(input logic [1:0] c, input logic [14:0] x,
            input logic [7:0] w);
        int n;
        n = 0;
        i_cmd = c;
        i_addr = x;
        i_wdata = w;
        i_start = 1'b1;
        @(negedge i_clk_sys);
        i_start = 1'b0;
        while (done !== 1'b1 && n < 60000) begin
            @(negedge i_clk_sys);
            n++;
        end
        if (n >= 60000) failures++;
    endtask
    task automatic prog(input logic [14:0] x, input logic [7:0] w,
            input logic [7:0] n);
        logic [7:0] old;
        logic [15:0] p0;
        old = stored(x);
        run(eprom_host_pkg::CMD_READ, x, 8'h00);
        chk("read_before", old, rdata);
        p0 = ptot;
        needed = n;
        run(eprom_host_pkg::CMD_PROG, x, w);
        chk("fail_flag", {7'h00, exp_fail(old, w)}, {7'h00, fail});
        chk("pulses", exp_pulses(old, w, n), 8'(ptot - p0));
        shadow[int'(x)] = old & w;
        run(eprom_host_pkg::CMD_READ, x, 8'h00);
        chk("readback", old & w, rdata);
        $display("test program %h done", x);
    endtask
    task automatic summarize();
        $display("checked %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // ========================================================
    // Identification keeps other address lines low at normal supply
    always @(negedge i_clk_sys) begin
        if (sig === 1'b1) begin
            chk("id_addr", 8'h00, {7'h00, |addr_lines[14:1]});
            chk("id_supply", 8'h00, {7'h00, vpp});
        end
        // Gate low at normal supply is a read, which needs the part selected
        if (vpp === 1'b0 && gate_n === 1'b0) begin
            chk("read_select", 8'h00, {7'h00, sel_n});
        end
    end
    // Watchdog sized above the longest expected run
    initial begin
        #(90000 * 50);
        failures++;
        summarize();
    end
    // ========================================================
    // Main sequence
    initial begin
        i_nrst = 1'b0;
        i_start = 1'b0;
        i_cmd = 2'h0;
        i_addr = 15'h0000;
        i_wdata = 8'h00;
        needed = 8'h01;
        seed = 32'h1bb83609;
        failures = 0;
        samples_checked = 0;
        repeat (20) @(negedge i_clk_sys);
        chk("reset_pins", 8'h07, {busy, done, fail, vpp, sig, sel_n,
            gate_n, oe_n});
        i_nrst = 1'b1;
        @(negedge i_clk_sys);
        for (int i = 0; i < 2; i++) begin
            run(eprom_host_pkg::CMD_IDENT, 15'(i), 8'h00);
            chk("ident", (i == 1) ? PART : MAKER, rdata);
        end
        $display("test identify done");
        // Corner addresses, all-zero and blank bytes among random ones
        for (int i = 0; i < 6; i++) begin
            a = (i == 0) ? 15'h0000 : (i == 1) ? 15'h7FFF : 15'($random(seed));
            d = (i == 0) ? 8'h00 : (i == 5) ? 8'hFF : 8'($random(seed));
            prog(a, d, 8'(1 + ($random(seed) & 1)));
        end
        // Asking for ones over programmed zeros must give up
        prog(15'h0000, 8'h0F, 8'h01);
        chk("inhibit_pulses", 8'h00, {7'h00, |ptot_idle});
        summarize();
    end
endmodule // tb_eprom_access_control
